// [common/erc_pkg.sv]
// Constants and types of the exception and reset control block
package erc_pkg;

  // ==========================================================
  // Exception vectors
  localparam logic [7:0] VEC_DEBUG       = 8'h01;
  localparam logic [7:0] VEC_NMI         = 8'h02;
  localparam logic [7:0] VEC_INVALID_OP  = 8'h06;
  localparam logic [7:0] VEC_NO_COPROC   = 8'h07;
  localparam logic [7:0] VEC_DOUBLE      = 8'h08;
  localparam logic [7:0] VEC_BAD_TSS     = 8'h0a;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] VEC_STACK       = 8'h0c;
  localparam logic [7:0] VEC_GEN_PROT    = 8'h0d;
  localparam logic [7:0] VEC_PAGE        = 8'h0e;
  localparam logic [7:0] VEC_COPROC_ERR  = 8'h10;

  // ==========================================================
  // Field positions
  localparam int FLG_STEP   = 8;
  localparam int FLG_IE     = 9;
  localparam int FLG_RESUME = 16;
  localparam int FLG_V86    = 17;
  localparam int MCW_PE     = 0;
  localparam int MCW_MP     = 1;
  localparam int MCW_EM     = 2;
  localparam int MCW_TS     = 3;
  localparam int MCW_ET     = 4;
  localparam int MCW_PG     = 31;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] RST_FLAGS     = 32'h00000002;
  localparam logic [31:0] FLAGS_MASK    = 32'h0003ffff;
  localparam logic [31:0] RST_MCW       = 32'h00000000;
  localparam logic [31:0] MCW_MASK      = 32'h8000001f;
  localparam logic [31:0] RST_IP        = 32'h0000fff0;
  localparam logic [15:0] RST_CS        = 16'hf000;
  localparam logic [31:0] RST_CS_BASE   = 32'hffff0000;
  localparam logic [31:0] RST_CS_LIMIT  = 32'h0000ffff;
  localparam logic [15:0] RST_SEG       = 16'h0000;
  localparam logic [31:0] RST_ACC       = 32'h00000000;
  // Identifier value is arbitrary
  localparam logic [31:0] COMPONENT_ID  = 32'h00000a5c;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFS_FLAGS    = 6'h00;
  localparam logic [5:0] OFS_MCW      = 6'h04;
  localparam logic [5:0] OFS_IP       = 6'h08;
  localparam logic [5:0] OFS_CS       = 6'h0c;
  localparam logic [5:0] OFS_CS_BASE  = 6'h10;
  localparam logic [5:0] OFS_CS_LIMIT = 6'h14;
  localparam logic [5:0] OFS_SEG0     = 6'h18;
  localparam logic [5:0] OFS_ACC      = 6'h2c;
  localparam logic [5:0] OFS_ID       = 6'h30;
  localparam logic [5:0] OFS_STATUS   = 6'h34;
  localparam int         NUM_SEG      = 5;

  // ==========================================================
  // Counts
  localparam logic [4:0] MAX_INSTR_LEN      = 5'h0f;
  localparam int         WAIT_PERIODS       = 400;
  localparam int         CLK_PER_PERIOD     = 1;
  localparam int         RESET_WAIT_CYC     = WAIT_PERIODS * CLK_PER_PERIOD;
  localparam int         SELFTEST_CYC_DEF   = 524288;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_RESET,
    ST_SELFTEST,
    ST_WAIT,
    ST_RUN
  } erc_state_t;

  typedef enum logic [1:0] {
    CLS_OTHER,
    CLS_SEGMENT,
    CLS_PAGE
  } erc_class_t;

endpackage

// [rtl/erc_selftest.sv]
// Built-in self-test sequencer with signature result
`timescale 1ns/1ps
module erc_selftest
  import erc_pkg::*;
#(
  parameter int CYCLES = SELFTEST_CYC_DEF
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [31:0]      result_o
);

  logic [19:0] cnt_q;
  logic [31:0] ref_q;
  logic [31:0] dut_q;
  logic [31:0] diff_q;

  // ==========================================================
  // Twin pattern generators; any divergence is a flaw
  always_ff @(posedge clk_i)
  begin
    if (rst_i || start_i)
    begin
      cnt_q  <= 20'h00000;
      ref_q  <= 32'h00000001;
      dut_q  <= 32'h00000001;
      diff_q <= 32'h00000000;
      busy_o <= start_i;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (busy_o)
      begin
        cnt_q  <= cnt_q + 20'h00001;
        ref_q  <= {ref_q[30:0], ref_q[31] ^ ref_q[21] ^ ref_q[1] ^ ref_q[0]};
        dut_q  <= {dut_q[30:0], dut_q[31] ^ dut_q[21] ^ dut_q[1] ^ dut_q[0]};
        diff_q <= diff_q | (ref_q ^ dut_q);
        if (cnt_q == 20'(CYCLES - 1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  assign result_o = diff_q;

endmodule

// [rtl/erc_top.sv]
// Exception ordering, reset sequencing and self-test control of the core
`timescale 1ns/1ps
//
// Functional notes
// - NMI and maskable together: NMI first, maskable only if enabled.
// - Maskable interrupt taken only when its input is high and enabled.
// - Problem enters its handler at once; instruction stays restartable.
// - Exactly one exception per execution attempt; others show on retries.
// - Order: debug traps, then NMI and maskable, then exec breakpoint.
// - Then fetch segmentation faults 11 or 13, then fetch page fault.
// - Decode: illegal or protected-only opcode 6; long/privileged 13.
// - Wait opcode with task-switched and monitor flags both set gives 7.
// - Escape opcode with emulate or task-switched flag set gives 7.
// - Wait or escape with coprocessor error asserted gives 16.
// - Per memory reference: segmentation faults before page fault.
// - Non-page fault entering handlers 10..13 gives double fault.
// - Any fault entering the page-fault handler becomes double fault.
// - Reset loads pointer, code segment, base, limit; data segments zero.
// - Reset clears flags word except bit 1, which reads one.
// - Reset clears control word fields; coprocessor type bit from strap.
// - Identifier register holds the part id; accumulator gets signature.
// - Upper address lines high until first intersegment jump or call.
// - While reset is asserted no instruction or bus cycle starts.
// - Fetching starts 350 to 450 clock periods after reset release or self-test end.
// - Self-test starts on reset release only while busy input is low.
// - Self-test runs about 2**19 clocks, then resets; zero means pass.
module erc_top
  import erc_pkg::*;
#(
  parameter int SELFTEST_CYCLES = SELFTEST_CYC_DEF
)
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [5:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // External party
  input  wire logic        NMI_I,
  input  wire logic        MASKABLE_IRQ_IN_I,
  input  wire logic        COPROC_ERROR_N_I,
  input  wire logic        COPROC_BUSY_N_I,
  input  wire logic        COPROC_TYPE_I,
  // Core status at the instruction boundary
  input  wire logic        BOUNDARY_I,
  input  wire logic        DATA_BKPT_I,
  input  wire logic        EXEC_BKPT_I,
  input  wire logic        FETCH_SEG_FAULT_I,
  input  wire logic        FETCH_SEG_GP_I,
  input  wire logic        FETCH_PAGE_FAULT_I,
  input  wire logic        ILLEGAL_OP_I,
  input  wire logic        PROT_ONLY_OP_I,
  input  wire logic [4:0]  INSTR_LEN_I,
  input  wire logic        PRIV_VIOL_I,
  input  wire logic        WAIT_OP_I,
  input  wire logic        ESC_OP_I,
  input  wire logic        MEM_SEG_FAULT_I,
  input  wire logic [1:0]  MEM_SEG_KIND_I,
  input  wire logic        MEM_PAGE_FAULT_I,
  // Core status during handler entry
  input  wire logic        ENTRY_DONE_I,
  input  wire logic        ENTRY_FAULT_I,
  input  wire logic        ENTRY_PAGE_FAULT_I,
  input  wire logic [7:0]  ENTRY_VEC_I,
  input  wire logic        IRET_I,
  input  wire logic        FAR_XFER_I,
  // Core control
  output logic             RUN_O,
  output logic             FETCH_START_O,
  output logic      [31:0] FETCH_ADDR_O,
  output logic             EXC_VALID_O,
  output logic      [7:0]  EXC_VECTOR_O,
  output logic             INTA_REQ_O,
  output logic             UPPER_ADDR_HIGH_O,
  output logic             SELFTEST_BUSY_O
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction

  function automatic logic [7:0] seg_vec(input logic [1:0] kind);
    case (kind)
      2'h0:    return VEC_NOT_PRESENT;
      2'h1:    return VEC_STACK;
      default: return VEC_GEN_PROT;
    endcase
  endfunction

  function automatic erc_class_t vec_class(input logic [7:0] vec);
    if (vec >= VEC_BAD_TSS && vec <= VEC_GEN_PROT)
      return CLS_SEGMENT;
    else if (vec == VEC_PAGE)
      return CLS_PAGE;
    else
      return CLS_OTHER;
  endfunction

  // ==========================================================
  // Declarations
  erc_state_t  state_q;
  erc_class_t  class_q;
  logic [8:0]  wait_cnt_q;
  logic        busy_n_rst_q;
  logic        arch_load;
  logic        st_start;
  logic        st_busy;
  logic        st_done;
  logic [31:0] st_result;
  logic [31:0] flags_q;
  logic [31:0] mcw_q;
  logic [31:0] ip_q;
  logic [15:0] cs_q;
  logic [31:0] cs_base_q;
  logic [31:0] cs_limit_q;
  logic [15:0] seg_q [NUM_SEG];
  logic [31:0] acc_q;
  logic        ack_q;
  logic        bus_req;
  logic        bus_wr;
  logic        entry_q;
  logic        nmi_pend_q;
  logic        nmi_block_q;
  logic        nmi_in_q;
  logic        upper_high_q;
  logic        chk_hit;
  logic        chk_nmi;
  logic        chk_maskable_irq_in;
  logic [7:0]  chk_vec;
  logic        take;
  logic        coproc_op;

  assign bus_req = CYC_I && STB_I && !ack_q;
  assign bus_wr  = bus_req && WE_I;

  // ==========================================================
  // Reset and self-test sequencing
  assign st_start  = (state_q == ST_RESET) && !busy_n_rst_q;
  assign arch_load = RST_I || st_done;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      state_q      <= ST_RESET;
      wait_cnt_q   <= 9'h000;
      busy_n_rst_q <= COPROC_BUSY_N_I;
    end
    else
    begin
      case (state_q)
        ST_RESET:
          state_q <= busy_n_rst_q ? ST_WAIT : ST_SELFTEST;
        ST_SELFTEST:
          if (st_done)
            state_q <= ST_WAIT;
        ST_WAIT:
        begin
          wait_cnt_q <= wait_cnt_q + 9'h001;
          if (wait_cnt_q == 9'(RESET_WAIT_CYC - 1))
            state_q <= ST_RUN;
        end
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      RUN_O         <= 1'b0;
      FETCH_START_O <= 1'b0;
      FETCH_ADDR_O  <= 32'h00000000;
    end
    else
    begin
      FETCH_START_O <= 1'b0;
      if (state_q == ST_WAIT && wait_cnt_q == 9'(RESET_WAIT_CYC - 1))
      begin
        RUN_O         <= 1'b1;
        FETCH_START_O <= 1'b1;
        FETCH_ADDR_O  <= cs_base_q + ip_q;
      end
    end
  end

  erc_selftest #(
    .CYCLES   (SELFTEST_CYCLES)
  ) u_selftest (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RST_I),
    .start_i  (st_start),
    .busy_o   (st_busy),
    .done_o   (st_done),
    .result_o (st_result)
  );

  always_ff @(posedge SYS_CLK_I)
  begin
    SELFTEST_BUSY_O <= !RST_I && (st_start || (st_busy && !st_done));
  end

  // ==========================================================
  // Architectural state loaded at reset
  always_ff @(posedge SYS_CLK_I)
  begin
    if (arch_load)
    begin
      ip_q       <= RST_IP;
      cs_q       <= RST_CS;
      cs_base_q  <= RST_CS_BASE;
      cs_limit_q <= RST_CS_LIMIT;
    end
  end

  for (genvar g = 0; g < NUM_SEG; g++)
  begin : g_seg
    always_ff @(posedge SYS_CLK_I)
    begin
      if (arch_load)
        seg_q[g] <= RST_SEG;
      else if (bus_wr && ADR_I == OFS_SEG0 + 6'(4 * g))
        seg_q[g] <= 16'(merge({16'h0000, seg_q[g]}, DAT_I, SEL_I));
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      acc_q <= RST_ACC;
    else if (st_done)
      acc_q <= st_result;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (arch_load)
    begin
      mcw_q         <= RST_MCW;
      mcw_q[MCW_ET] <= COPROC_TYPE_I;
    end
    else if (bus_wr && ADR_I == OFS_MCW)
      mcw_q <= merge(mcw_q, DAT_I, SEL_I) & MCW_MASK;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (arch_load)
      flags_q <= RST_FLAGS;
    else if (take && (chk_nmi || chk_maskable_irq_in))
      flags_q[FLG_IE] <= 1'b0;
    else if (bus_wr && ADR_I == OFS_FLAGS)
      flags_q <= (merge(flags_q, DAT_I, SEL_I) & FLAGS_MASK) | RST_FLAGS;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (arch_load)
      upper_high_q <= 1'b1;
    else if (RUN_O && FAR_XFER_I)
      upper_high_q <= 1'b0;
  end

  assign UPPER_ADDR_HIGH_O = upper_high_q;

  // ==========================================================
  // Check sequence at each instruction boundary
  assign coproc_op = WAIT_OP_I || ESC_OP_I;

  always_comb
  begin
    chk_hit  = 1'b1;
    chk_nmi  = 1'b0;
    chk_maskable_irq_in = 1'b0;
    chk_vec  = VEC_DEBUG;
    if (flags_q[FLG_STEP] || DATA_BKPT_I)
      chk_vec = VEC_DEBUG;
    else if (nmi_pend_q && !nmi_block_q)
    begin
      chk_nmi = 1'b1;
      chk_vec = VEC_NMI;
    end
    else if (MASKABLE_IRQ_IN_I && flags_q[FLG_IE])
      chk_maskable_irq_in = 1'b1;
    else if (EXEC_BKPT_I && !flags_q[FLG_RESUME])
      chk_vec = VEC_DEBUG;
    else if (FETCH_SEG_FAULT_I)
      chk_vec = seg_vec({FETCH_SEG_GP_I, 1'b0});
    else if (FETCH_PAGE_FAULT_I)
      chk_vec = VEC_PAGE;
    else if (ILLEGAL_OP_I || (PROT_ONLY_OP_I &&
             (!mcw_q[MCW_PE] || flags_q[FLG_V86])))
      chk_vec = VEC_INVALID_OP;
    else if (INSTR_LEN_I > MAX_INSTR_LEN || (PRIV_VIOL_I &&
             mcw_q[MCW_PE]))
      chk_vec = VEC_GEN_PROT;
    else if (WAIT_OP_I && mcw_q[MCW_TS] && mcw_q[MCW_MP])
      chk_vec = VEC_NO_COPROC;
    else if (ESC_OP_I && (mcw_q[MCW_EM] || mcw_q[MCW_TS]))
      chk_vec = VEC_NO_COPROC;
    else if (coproc_op && !COPROC_ERROR_N_I)
      chk_vec = VEC_COPROC_ERR;
    else if (MEM_SEG_FAULT_I)
      chk_vec = seg_vec(MEM_SEG_KIND_I);
    else if (MEM_PAGE_FAULT_I)
      chk_vec = VEC_PAGE;
    else
      chk_hit = 1'b0;
  end

  assign take = RUN_O && !entry_q && BOUNDARY_I && chk_hit;

  // ==========================================================
  // Raising exceptions and handler entry
  always_ff @(posedge SYS_CLK_I)
  begin
    if (arch_load)
    begin
      entry_q      <= 1'b0;
      class_q      <= CLS_OTHER;
      EXC_VALID_O  <= 1'b0;
      EXC_VECTOR_O <= 8'h00;
      INTA_REQ_O   <= 1'b0;
    end
    else
    begin
      EXC_VALID_O <= 1'b0;
      INTA_REQ_O  <= 1'b0;
      if (entry_q && ENTRY_FAULT_I)
      begin
        EXC_VALID_O <= 1'b1;
        if ((class_q == CLS_SEGMENT && !ENTRY_PAGE_FAULT_I) ||
            class_q == CLS_PAGE)
        begin
          EXC_VECTOR_O <= VEC_DOUBLE;
          class_q      <= CLS_OTHER;
        end
        else
        begin
          EXC_VECTOR_O <= ENTRY_VEC_I;
          class_q      <= vec_class(ENTRY_VEC_I);
        end
      end
      else if (entry_q && ENTRY_DONE_I)
        entry_q <= 1'b0;
      else if (take)
      begin
        entry_q <= 1'b1;
        class_q <= chk_maskable_irq_in ? CLS_OTHER : vec_class(chk_vec);
        if (chk_maskable_irq_in)
          INTA_REQ_O <= 1'b1;
        else
        begin
          EXC_VALID_O  <= 1'b1;
          EXC_VECTOR_O <= chk_vec;
        end
      end
    end
  end

  // ==========================================================
  // NMI latch and blocking until interrupt return
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      nmi_in_q    <= 1'b0;
      nmi_pend_q  <= 1'b0;
      nmi_block_q <= 1'b0;
    end
    else
    begin
      nmi_in_q <= NMI_I;
      if (NMI_I && !nmi_in_q)
        nmi_pend_q <= 1'b1;
      else if (take && chk_nmi)
        nmi_pend_q <= 1'b0;
      if (take && chk_nmi)
        nmi_block_q <= 1'b1;
      else if (IRET_I)
        nmi_block_q <= 1'b0;
    end
  end

  // ==========================================================
  // Wishbone register access
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ack_q <= 1'b0;
      DAT_O <= 32'h00000000;
    end
    else
    begin
      ack_q <= bus_req;
      if (bus_req)
      begin
        case (ADR_I)
          OFS_FLAGS:    DAT_O <= flags_q;
          OFS_MCW:      DAT_O <= mcw_q;
          OFS_IP:       DAT_O <= ip_q;
          OFS_CS:       DAT_O <= {16'h0000, cs_q};
          OFS_CS_BASE:  DAT_O <= cs_base_q;
          OFS_CS_LIMIT: DAT_O <= cs_limit_q;
          OFS_SEG0:     DAT_O <= {16'h0000, seg_q[0]};
          6'h1c:        DAT_O <= {16'h0000, seg_q[1]};
          6'h20:        DAT_O <= {16'h0000, seg_q[2]};
          6'h24:        DAT_O <= {16'h0000, seg_q[3]};
          6'h28:        DAT_O <= {16'h0000, seg_q[4]};
          OFS_ACC:      DAT_O <= acc_q;
          OFS_ID:       DAT_O <= COMPONENT_ID;
          OFS_STATUS:   DAT_O <= {16'h0000, EXC_VECTOR_O,
                                  state_q, 2'h0, entry_q, nmi_block_q,
                                  nmi_pend_q, upper_high_q};
          default:      DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  assign ACK_O = ack_q;

endmodule

// [tb/erc_props.sv]
// Concurrent checks on the ports of the exception and reset block
`timescale 1ns/1ps
module erc_props
  import erc_pkg::*;
#(
  parameter int SELFTEST_CYCLES = SELFTEST_CYC_DEF
)
(
  // Clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RST_I,
  // Bus and far side
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        ACK_O,
  input wire logic        COPROC_BUSY_N_I,
  // Core status and control
  input wire logic        BOUNDARY_I,
  input wire logic        ENTRY_FAULT_I,
  input wire logic        FAR_XFER_I,
  input wire logic        RUN_O,
  input wire logic        FETCH_START_O,
  input wire logic [31:0] FETCH_ADDR_O,
  input wire logic        EXC_VALID_O,
  input wire logic        INTA_REQ_O,
  input wire logic        UPPER_ADDR_HIGH_O,
  input wire logic        SELFTEST_BUSY_O
);
  logic [9:0] wait_q;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ========
  // Cycles waited for the first fetch
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I || SELFTEST_BUSY_O)
      wait_q <= 10'h000;
    else if (!RUN_O)
      wait_q <= wait_q + 10'h001;
  end
  // ========
  // Assertions
  ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not answered");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  one_event_a: assert property (!(EXC_VALID_O && INTA_REQ_O))
    else $error("two events at once");
  event_cause_a: assert property (EXC_VALID_O || INTA_REQ_O |->
    $past(BOUNDARY_I) || $past(ENTRY_FAULT_I))
    else $error("event without cause");
  idle_boundary_a: assert property (BOUNDARY_I && !RUN_O |=>
    !EXC_VALID_O && !INTA_REQ_O)
    else $error("event while idle");
  reset_idle_a: assert property (disable iff (1'b0) RST_I |=>
    !RUN_O && !FETCH_START_O && UPPER_ADDR_HIGH_O)
    else $error("activity during reset");
  fetch_addr_a: assert property (FETCH_START_O |->
    FETCH_ADDR_O == 32'hfffffff0 && $rose(RUN_O))
    else $error("bad first fetch");
  start_window_a: assert property ($rose(RUN_O) |->
    wait_q >= 10'h15e && wait_q <= 10'h1c2)
    else $error("start outside window");
  start_bound_a: assert property (wait_q <= 10'h1c2)
    else $error("start too late");
  test_go_a: assert property ($fell(RST_I) &&
    !$past(COPROC_BUSY_N_I) |=> SELFTEST_BUSY_O)
    else $error("self-test not started");
  test_skip_a: assert property ($fell(RST_I) &&
    $past(COPROC_BUSY_N_I) |=> !SELFTEST_BUSY_O [*4])
    else $error("self-test started unasked");
  far_drop_a: assert property (FAR_XFER_I && RUN_O |=>
    !UPPER_ADDR_HIGH_O)
    else $error("upper lines kept high");
  upper_hold_a: assert property ($fell(UPPER_ADDR_HIGH_O) |->
    $past(FAR_XFER_I))
    else $error("upper lines dropped early");
  cover property ($rose(RUN_O));
  cover property (INTA_REQ_O);
  cover property (EXC_VALID_O);
  cover property ($fell(SELFTEST_BUSY_O));
endmodule

// [tb/erc_partner.sv]
// Model of the interrupt controller and the coprocessor
`timescale 1ns/1ps
module erc_partner
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Bench requests and acknowledge
  input  wire logic nmi_req_i,
  input  wire logic irq_req_i,
  input  wire logic err_req_i,
  input  wire logic busy_req_i,
  input  wire logic inta_i,
  // Lines into the block
  output logic      nmi_o,
  output logic      irq_o,
  output logic      err_n_o,
  output logic      busy_n_o,
  output logic      type_o
);
  logic irq_q;
  // ========
  // Request held until acknowledged
  always_ff @(posedge clk_i)
  begin
    if (rst_i || inta_i)
      irq_q <= 1'b0;
    else if (irq_req_i)
      irq_q <= 1'b1;
  end
  assign irq_o    = irq_q;
  assign nmi_o    = nmi_req_i;
  assign err_n_o  = ~err_req_i;
  assign busy_n_o = ~busy_req_i;
  // Newer coprocessor fitted
  assign type_o   = 1'b1;
endmodule

// [tb/testbench.sv]
// Self-checking bench of the exception and reset control block
`timescale 1ns/1ps
module testbench;
  import erc_pkg::*;
  // ========
  // Signals
  localparam int STC = 64;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic        bnd = 1'b0, nrq = 1'b0, irq = 1'b0, brq = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0;
  logic [15:0] st = 16'h0;
  logic [4:0]  ent = 5'h0;
  logic [7:0]  ev8 = 8'h0;
  logic [31:0] rdat, fadr, fa, q;
  logic        ack, run, fst, ev, ia, up, stb, nmi, mi, errn, bsyn, typ;
  logic [7:0]  vec;
  int          error_cnt = 0, checks_done = 0, ncyc = 0;
  time         t0, tr;
  logic [31:0] tbl [19] = '{32'h000ffe01, 32'h000ffc0d, 32'h000ff40b,
    32'h000ff00e, 32'h001fe006, 32'h001f800d, 32'h00004006, 32'h000300ff,
    32'h00830010, 32'h0a810007, 32'h0a020007, 32'h040100ff, 32'h04020007,
    32'h020100ff, 32'h002c000c, 32'h0008000e, 32'h0044000d, 32'h0004000b,
    32'h0a010007};
  erc_top #(.SELFTEST_CYCLES(STC)) erc_top_i (.SYS_CLK_I(clk),
    .RST_I(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rdat), .ACK_O(ack), .NMI_I(nmi),
    .MASKABLE_IRQ_IN_I(mi), .COPROC_ERROR_N_I(errn),
    .COPROC_BUSY_N_I(bsyn), .COPROC_TYPE_I(typ), .BOUNDARY_I(bnd),
    .DATA_BKPT_I(st[0]), .EXEC_BKPT_I(st[1]), .FETCH_SEG_FAULT_I(st[2]),
    .FETCH_SEG_GP_I(st[3]), .FETCH_PAGE_FAULT_I(st[4]),
    .ILLEGAL_OP_I(st[5]), .PROT_ONLY_OP_I(st[6]), .PRIV_VIOL_I(st[7]),
    .INSTR_LEN_I(st[12] ? 5'h10 : 5'h04), .WAIT_OP_I(st[8]),
    .ESC_OP_I(st[9]), .MEM_SEG_FAULT_I(st[10]),
    .MEM_SEG_KIND_I(st[14:13]), .MEM_PAGE_FAULT_I(st[11]),
    .ENTRY_DONE_I(ent[0]), .ENTRY_FAULT_I(ent[1]),
    .ENTRY_PAGE_FAULT_I(ent[2]), .ENTRY_VEC_I(ev8), .IRET_I(ent[3]),
    .FAR_XFER_I(ent[4]), .RUN_O(run), .FETCH_START_O(fst),
    .FETCH_ADDR_O(fadr), .EXC_VALID_O(ev), .EXC_VECTOR_O(vec),
    .INTA_REQ_O(ia), .UPPER_ADDR_HIGH_O(up), .SELFTEST_BUSY_O(stb));
  erc_partner erc_partner_i (.clk_i(clk), .rst_i(rst), .nmi_req_i(nrq),
    .irq_req_i(irq), .err_req_i(st[15]), .busy_req_i(brq), .inta_i(ia),
    .nmi_o(nmi), .irq_o(mi), .err_n_o(errn), .busy_n_o(bsyn),
    .type_o(typ));
  always #50 clk = ~clk;
  // ========
  // First fetch capture and timeout
  always @(posedge clk)
  begin
    ncyc++;
    if (fst === 1'b1)
    begin
      tr = $time;
      fa = fadr;
    end
    if (ncyc == 5000)
    begin
      error_cnt++;
      results();
    end
  end
  // ========
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    chk(n, 1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic ex(input logic [15:0] s, input logic [7:0] e,
                    input logic i);
    logic n;
    n = (e == 8'hff);
    @(posedge clk);
    st <= s;
    bnd <= 1'b1;
    @(posedge clk);
    bnd <= 1'b0;
    @(posedge clk);
    chk({22'h0, ia, ev, n ? 8'h0 : vec}, {22'h0, i, !n, n ? 8'h0 : e});
  endtask
  task automatic pulse(input logic [4:0] p, input logic [7:0] v);
    @(posedge clk);
    ent <= p;
    ev8 <= v;
    @(posedge clk);
    ent <= 5'h0;
    @(posedge clk);
  endtask
  task automatic flt(input logic pg, input logic [7:0] v, e);
    pulse({2'b00, pg, 2'b10}, v);
    chk({23'h0, ev, vec}, {24'h1, e});
  endtask
  task automatic rstp(input logic b);
    @(posedge clk);
    brq <= b;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    brq <= 1'b0;
    t0 = $time;
  endtask
  task automatic results();
    $display("Mismatches %0d in %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ========
  // Main sequence
  initial
  begin
    rstp(1'b0);
    chk(32'(up), 32'h1);
    rd(OFS_FLAGS, 32'h00000002);
    rd(OFS_MCW, 32'h00000010);
    rd(OFS_IP, 32'h0000fff0);
    rd(OFS_CS, 32'h0000f000);
    rd(OFS_CS_BASE, 32'hffff0000);
    rd(OFS_CS_LIMIT, 32'h0000ffff);
    for (int k = 0; k < 5; k++)
      rd(OFS_SEG0 + 6'(4 * k), 32'h0);
    rd(OFS_ACC, 32'h0);
    rd(OFS_ID, COMPONENT_ID);
    rd(6'h38, 32'h0);
    ex(16'h0020, 8'hff, 1'b0);
    wr(OFS_MCW, 32'hffffffff);
    rd(OFS_MCW, 32'h8000001f);
    for (int k = 0; k < 500 && run !== 1'b1; k++)
      @(posedge clk);
    @(posedge clk);
    chk(32'(tr - t0 >= 35100 && tr - t0 <= 45100), 32'h1);
    chk(fa, 32'hfffffff0);
    foreach (tbl[k])
    begin
      wr(OFS_MCW, {24'h0, tbl[k][31:24]});
      ex(tbl[k][23:8], tbl[k][7:0], 1'b0);
      if (tbl[k][7:0] != 8'hff)
        pulse(5'h01, 8'h00);
    end
    wr(OFS_FLAGS, 32'h00000202);
    nrq <= 1'b1;
    irq <= 1'b1;
    ex(16'h0, 8'h02, 1'b0);
    nrq <= 1'b0;
    irq <= 1'b0;
    pulse(5'h01, 8'h00);
    rd(OFS_FLAGS, 32'h00000002);
    ex(16'h0, 8'hff, 1'b0);
    wr(OFS_FLAGS, 32'h00000202);
    ex(16'h0, 8'hff, 1'b1);
    pulse(5'h01, 8'h00);
    wr(OFS_FLAGS, 32'h00000202);
    ex(16'h0, 8'hff, 1'b0);
    pulse(5'h08, 8'h00);
    nrq <= 1'b1;
    ex(16'h0001, 8'h01, 1'b0);
    nrq <= 1'b0;
    pulse(5'h01, 8'h00);
    ex(16'h0, 8'h02, 1'b0);
    pulse(5'h01, 8'h00);
    ex(16'h0020, 8'h06, 1'b0);
    flt(1'b0, 8'h0d, 8'h0d);
    flt(1'b0, 8'h0c, 8'h08);
    pulse(5'h01, 8'h00);
    ex(16'h0400, 8'h0b, 1'b0);
    flt(1'b1, 8'h0e, 8'h0e);
    flt(1'b1, 8'h0e, 8'h08);
    pulse(5'h01, 8'h00);
    ex(16'h0800, 8'h0e, 1'b0);
    flt(1'b0, 8'h0d, 8'h08);
    pulse(5'h01, 8'h00);
    pulse(5'h10, 8'h00);
    chk(32'(up), 32'h0);
    rstp(1'b1);
    chk(32'(run), 32'h0);
    for (int k = 0; k < 8 && stb !== 1'b1; k++)
      @(posedge clk);
    chk(32'(stb), 32'h1);
    for (int k = 0; k < STC + 8 && stb === 1'b1; k++)
      @(posedge clk);
    chk(32'(stb), 32'h0);
    rd(OFS_ACC, 32'h0);
    rd(OFS_FLAGS, 32'h00000002);
    chk(32'(up), 32'h1);
    results();
  end
endmodule
bind erc_top erc_props #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) erc_props_i (.*);
